//--- logic/edge_detect.sv
`include "sched_regs.svh"
// edge detection for the event interrupt inputs
module edge_detect (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [`NUM_EVENT-1:0] level,
  input wire logic [2*`NUM_EVENT-1:0] edge_sel,
  output logic [`NUM_EVENT-1:0] hit
);
  logic [`NUM_EVENT-1:0] prev_q;
  logic [`NUM_EVENT-1:0] rise;
  logic [`NUM_EVENT-1:0] fall;
  logic [`NUM_EVENT-1:0] hit_w;

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;

  always_comb begin
    for (int i = 0; i < `NUM_EVENT; i++) begin
      case (edge_sel[2*i +: 2])
        `EDGE_RISE: hit_w[i] = rise[i];
        `EDGE_FALL: hit_w[i] = fall[i];
        `EDGE_BOTH: hit_w[i] = rise[i] | fall[i];
        default: hit_w[i] = 1'b0;
      endcase
    end
  end

  // previous level; reset clears it, so a high input gives a rising edge in the first cycle after reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_q <= '0;
      hit <= '0;
    end else begin
      prev_q <= level;
      hit <= hit_w;
    end
  end
endmodule // edge_detect

//--- logic/program_scheduler_error_handler.sv
// Function
// - scan runs step zero to last step
// - interrupt suspends scan, resumes at same step
// - eight periodic sources, each own period
// - six event sources on input changes
// - event edge: rising, falling or both
// - counter match starts its interrupt routine
// - subroutine runs only when called
// - faults sorted fatal stop, ordinary continue
// - record error flags on the same edge as stop
// - configuration mismatch forces stopped state
// - numeric fault flags, execution continues
// - watchdog or io failure forces stop
// - every error sets summary error flag
// - watchdog 10 to 6000 ms, 10 ms steps
// - watchdog expiry halts, outputs forced off
// - watchdog service clears elapsed time
`include "sched_regs.svh"
module program_scheduler_error_handler (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run_req,
  input wire logic [`STEP_W-1:0] last_step,
  input wire logic step_done,
  input wire logic call_req,
  input wire logic [`STEP_W-1:0] call_target,
  input wire logic sub_return,
  input wire logic isr_done,
  input wire logic [`NUM_PERIODIC-1:0] periodic_enable,
  input wire logic [`NUM_PERIODIC*`PERIOD_W-1:0] periodic_interrupt_setting,
  input wire logic [`NUM_EVENT-1:0] input_event_interrupt,
  input wire logic [`NUM_EVENT-1:0] event_enable,
  input wire logic [2*`NUM_EVENT-1:0] event_edge_sel,
  input wire logic counter_compare_interrupt,
  input wire logic [`WDOG_W-1:0] wdog_units,
  input wire logic watchdog_service_instruction,
  input wire logic config_mismatch,
  input wire logic io_fault,
  input wire logic numeric_fault,
  input wire logic hw_fatal_fault,
  input wire logic ext_fault,
  input wire logic ext_fault_fatal,
  input wire logic err_clear,
  output logic [`STEP_W-1:0] step_ptr,
  output logic in_isr,
  output logic [`SRC_W-1:0] interrupt_point_index,
  output logic in_sub,
  output logic running,
  output logic stopped,
  output logic outputs_off,
  output logic [`ERR_W-1:0] error_flags,
  output logic summary_error_flag,
  output logic warning
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  sched_pkg::exec_state_t state_q, state_d;
  logic [`STEP_W-1:0] step_q, step_d, saved_step_q, ret_step_q;
  logic in_sub_q, in_sub_d, sub_enter, sub_leave;
  logic [`SRC_W-1:0] isr_idx_q;
  logic [`NUM_SRC-1:0] pend_q;
  logic [`NUM_SRC-1:0] new_req;
  logic [`NUM_EVENT-1:0] evt_hit;
  logic cnt_prev_q;
  logic [`TICK_W-1:0] tick_cnt_q;
  logic tick;
  logic [`PERIOD_W-1:0] per_cnt_q [`NUM_PERIODIC];
  logic [`NUM_PERIODIC-1:0] per_fire;
  logic [`WDOG_MS_W-1:0] wdog_ms_q;
  logic [`WDOG_MS_W-1:0] wdog_limit_ms;
  logic [`WDOG_W-1:0] wdog_units_c;
  logic wdog_expire;
  logic [`ERR_W-1:0] err_q, err_set;
  logic fatal_now;
  logic grant;
  logic [`SRC_W-1:0] grant_idx;
  logic scan_end;

  // lowest-numbered pending source
  function automatic logic [`SRC_W-1:0] first_set(input logic [`NUM_SRC-1:0] v);
    logic [`SRC_W-1:0] r;
    r = '0;
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) r = `SRC_W'(i);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // interrupt sources
  // event edges
  edge_detect u_edge (
    .ref_clk(ref_clk),
    .rst(rst),
    .level(input_event_interrupt),
    .edge_sel(event_edge_sel),
    .hit(evt_hit)
  );

  // 1 ms tick, shared by periodic sources and watchdog
  assign tick = (tick_cnt_q == `TICK_W'(`TICK_CYCLES - 1));
  always_ff @(posedge ref_clk) begin
    if (rst || tick) tick_cnt_q <= '0;
    else tick_cnt_q <= tick_cnt_q + 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < `NUM_PERIODIC; i++) begin
      if (rst || !periodic_enable[i] || per_fire[i]) per_cnt_q[i] <= '0;
      else if (tick) per_cnt_q[i] <= per_cnt_q[i] + 1'b1;
    end
  end
  always_comb begin
    for (int i = 0; i < `NUM_PERIODIC; i++) begin
      per_fire[i] = periodic_enable[i] && tick &&
        (per_cnt_q[i] + 1'b1 >= periodic_interrupt_setting[i*`PERIOD_W +: `PERIOD_W]);
    end
  end

  // counter match rising edge is the request
  assign new_req = {counter_compare_interrupt & ~cnt_prev_q,
                    evt_hit & event_enable, per_fire};

  ////////////////////////////////////////////////////////////////////////
  // watchdog
  // clamp setting to 10..6000 ms
  assign wdog_units_c = (wdog_units < `WDOG_MIN_UNITS) ? `WDOG_MIN_UNITS :
                        (wdog_units > `WDOG_MAX_UNITS) ? `WDOG_MAX_UNITS : wdog_units;
  assign wdog_limit_ms = `WDOG_MS_W'(wdog_units_c * `WDOG_UNIT_MS);
  assign wdog_expire = (state_q == sched_pkg::ST_SCAN || state_q == sched_pkg::ST_ISR) &&
                       (wdog_ms_q >= wdog_limit_ms);

  // service instruction and end of scan both clear elapsed time
  always_ff @(posedge ref_clk) begin
    if (rst || watchdog_service_instruction || scan_end ||
        state_q == sched_pkg::ST_IDLE || state_q == sched_pkg::ST_STOP) wdog_ms_q <= '0;
    else if (tick && !wdog_expire) wdog_ms_q <= wdog_ms_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // error classification
  // sources into flags
  assign err_set[`ERR_CONFIG] = config_mismatch;
  assign err_set[`ERR_WDOG] = wdog_expire;
  assign err_set[`ERR_IO] = io_fault;
  assign err_set[`ERR_NUMERIC] = numeric_fault;
  assign err_set[`ERR_HW_FATAL] = hw_fatal_fault;
  assign err_set[`ERR_EXT_ORDINARY] = ext_fault;
  // fatal class; numeric and ordinary external faults continue
  assign fatal_now = config_mismatch | wdog_expire | io_fault | hw_fatal_fault |
                     (ext_fault & ext_fault_fatal);

  // flags latch in the same edge the stop is taken; set beats clear
  always_ff @(posedge ref_clk) begin
    if (rst) err_q <= '0;
    else err_q <= (err_clear ? '0 : err_q) | err_set;
  end

  ////////////////////////////////////////////////////////////////////////
  // scheduler
  assign scan_end = (state_q == sched_pkg::ST_SCAN) && step_done && !in_sub_q &&
                    (step_q == last_step) && !grant;
  assign grant = (state_q == sched_pkg::ST_SCAN) && (|pend_q);
  assign grant_idx = first_set(pend_q);

  // next step and state
  always_comb begin
    state_d = state_q;
    step_d = step_q;
    case (state_q)
      sched_pkg::ST_IDLE: begin
        if (run_req) begin
          state_d = sched_pkg::ST_SCAN;
          step_d = `STEP_ZERO;
        end
      end
      sched_pkg::ST_SCAN: begin
        // one at a time, lowest index first
        if (grant) begin
          state_d = sched_pkg::ST_ISR;
        end else if (call_req && !in_sub_q) begin
          step_d = call_target;
        end else if (sub_return && in_sub_q) begin
          step_d = ret_step_q;
        end else if (step_done) begin
          // wrap to step zero after last step
          step_d = (step_q == last_step && !in_sub_q) ? `STEP_ZERO : step_q + 1'b1;
        end
      end
      sched_pkg::ST_ISR: begin
        if (isr_done) state_d = sched_pkg::ST_SCAN;
      end
      sched_pkg::ST_STOP: begin
        if (err_clear && run_req) begin
          state_d = sched_pkg::ST_SCAN;
          step_d = `STEP_ZERO;
        end
      end
      default: state_d = sched_pkg::ST_STOP;
    endcase
    if (fatal_now) state_d = sched_pkg::ST_STOP;
  end

  // state and step
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= sched_pkg::ST_IDLE;
      step_q <= `STEP_ZERO;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
    end
  end

  // subroutine entry and exit; a stop in the same cycle wins over a call, so a
  // restart never begins inside a stale subroutine
  assign sub_enter = (state_q == sched_pkg::ST_SCAN) && !grant && call_req && !in_sub_q;
  assign sub_leave = (state_q == sched_pkg::ST_SCAN) && !grant && sub_return;
  assign in_sub_d = (state_d == sched_pkg::ST_STOP) ? 1'b0 : sub_enter ? 1'b1 :
                    sub_leave ? 1'b0 : in_sub_q;

  // save suspended step; save return step
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      saved_step_q <= `STEP_ZERO;
      ret_step_q <= `STEP_ZERO;
      in_sub_q <= 1'b0;
      isr_idx_q <= '0;
    end else begin
      if (grant) saved_step_q <= step_q;
      if (grant) isr_idx_q <= grant_idx;
      if (sub_enter) ret_step_q <= step_q + 1'b1;
      in_sub_q <= in_sub_d;
    end
  end

  // pending requests; a new request beats the grant clear of its own bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_q <= '0;
      cnt_prev_q <= 1'b0;
    end else begin
      cnt_prev_q <= counter_compare_interrupt;
      if (state_d == sched_pkg::ST_STOP) pend_q <= '0;
      else pend_q <= (pend_q & ~(grant ? (`NUM_SRC'(1) << grant_idx) : '0)) |
                     (new_req & {`NUM_SRC{state_q != sched_pkg::ST_IDLE}});
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  // summary flag follows any error
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      step_ptr <= `STEP_ZERO;
      in_isr <= 1'b0;
      interrupt_point_index <= '0;
      in_sub <= 1'b0;
      running <= 1'b0;
      stopped <= 1'b0;
      outputs_off <= 1'b1;
      error_flags <= '0;
      summary_error_flag <= 1'b0;
      warning <= 1'b0;
    end else begin
      step_ptr <= step_d;
      in_isr <= (state_d == sched_pkg::ST_ISR);
      interrupt_point_index <= grant ? grant_idx : isr_idx_q;
      in_sub <= in_sub_d; // same edge as the step jump
      running <= (state_d == sched_pkg::ST_SCAN || state_d == sched_pkg::ST_ISR);
      stopped <= (state_d == sched_pkg::ST_STOP);
      outputs_off <= !(state_d == sched_pkg::ST_SCAN || state_d == sched_pkg::ST_ISR);
      error_flags <= (err_clear ? '0 : err_q) | err_set;
      summary_error_flag <= |((err_clear ? '0 : err_q) | err_set);
      warning <= ((err_clear ? 1'b0 : (err_q[`ERR_NUMERIC] | err_q[`ERR_EXT_ORDINARY])) |
                  numeric_fault | (ext_fault & !ext_fault_fatal));
    end
  end
endmodule // program_scheduler_error_handler

//--- logic/sched_pkg.sv
package sched_pkg;
  // executor states, gray coded along run -> interrupt -> run
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SCAN = 2'h1,
    ST_ISR = 2'h3,
    ST_STOP = 2'h2
  } exec_state_t;
endpackage

//--- logic/sched_regs.svh
`ifndef SCHED_REGS_SVH
`define SCHED_REGS_SVH
// program step counter width and first step
`define STEP_W 16
`define STEP_ZERO 16'h0000
// periodic sources, event sources
`define NUM_PERIODIC 8
`define NUM_EVENT 6
`define NUM_SRC 15
`define SRC_W 4
`define SRC_CNT_IDX 4'he
// periodic period counter width (in ticks of 1 ms)
`define PERIOD_W 16
// time base: 1 ms at 200 MHz (5 ns period)
`define CLK_PERIOD_NS 5
`define TICK_NS 1000000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define TICK_W 18
// watchdog: 10 ms units, 10..6000 ms
`define WDOG_UNIT_MS 10
`define WDOG_MIN_UNITS 10'h001
`define WDOG_MAX_UNITS 10'h258
`define WDOG_W 10
`define WDOG_MS_W 14
// edge select encodings
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_BOTH 2'h2
// error flag bit positions
`define ERR_W 6
`define ERR_CONFIG 0
`define ERR_WDOG 1
`define ERR_IO 2
`define ERR_NUMERIC 3
`define ERR_HW_FATAL 4
`define ERR_EXT_ORDINARY 5
`endif

//--- testbench/event_partner.sv
`include "sched_regs.svh"
// far side: event input lines and counter compare match
module event_partner (
  input wire logic ref_clk,
  output logic [`NUM_EVENT-1:0] input_event_interrupt,
  output logic counter_compare_interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    input_event_interrupt = 6'h00;
    counter_compare_interrupt = 1'h0;
  end
  // levels move off the sampling edge
  task automatic set_events(input logic [`NUM_EVENT-1:0] v);
    @(negedge ref_clk);
    input_event_interrupt = v;
  endtask
  // match held several cycles, as a slow counter would
  task automatic pulse_match(input int hold);
    @(negedge ref_clk);
    counter_compare_interrupt = 1'h1;
    repeat (hold) @(negedge ref_clk);
    counter_compare_interrupt = 1'h0;
  endtask
endmodule // event_partner

//--- testbench/sched_checker.sv
`include "sched_regs.svh"
// watches the scheduler ports only
module sched_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [`STEP_W-1:0] last_step,
  input wire logic step_done,
  input wire logic call_req,
  input wire logic isr_done,
  input wire logic config_mismatch,
  input wire logic io_fault,
  input wire logic hw_fatal_fault,
  input wire logic numeric_fault,
  input wire logic ext_fault,
  input wire logic ext_fault_fatal,
  input wire logic [`STEP_W-1:0] step_ptr,
  input wire logic in_isr,
  input wire logic in_sub,
  input wire logic running,
  input wire logic stopped,
  input wire logic outputs_off,
  input wire logic [`ERR_W-1:0] error_flags,
  input wire logic summary_error_flag,
  input wire logic warning
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // a fatal fault or a call in the same cycle changes the step path, so exclude them
  wire fatal_in = config_mismatch | io_fault | hw_fatal_fault | (ext_fault & ext_fault_fatal);
  wire scan_step = running & ~in_isr & ~in_sub & step_done & ~call_req & ~fatal_in;
  //////////////////////////////////////////////////////////////////////////////
  // mismatch forces stop
  cfg_stop_a: assert property (
    running && config_mismatch |=> stopped && outputs_off && error_flags[`ERR_CONFIG])
    else $error("config fault did not stop");
  fatal_off_a: assert property (
    running && (io_fault || hw_fatal_fault) |=> stopped && outputs_off)
    else $error("fatal fault did not stop");
  numeric_go_a: assert property (
    running && numeric_fault && !fatal_in |=> !stopped && error_flags[`ERR_NUMERIC] && warning)
    else $error("numeric fault mishandled");
  summary_a: assert property (
    summary_error_flag == (|error_flags)) else $error("summary flag wrong");
  isr_resume_a: assert property (
    in_isr && isr_done && !fatal_in |=> !in_isr && step_ptr == $past(step_ptr))
    else $error("bad resume");
  step_next_a: assert property (
    scan_step && step_ptr != last_step |=> step_ptr == $past(step_ptr) + 16'h0001 || in_isr)
    else $error("step did not advance");
  step_wrap_a: assert property (
    scan_step && step_ptr == last_step |=> step_ptr == 16'h0000 || in_isr)
    else $error("scan did not wrap");
  call_only_a: assert property (
    $rose(in_sub) |-> $past(call_req)) else $error("subroutine without call");
endmodule // sched_checker

bind program_scheduler_error_handler sched_checker sched_checker_i (.ref_clk, .rst,
  .last_step, .step_done, .call_req, .isr_done, .config_mismatch, .io_fault,
  .hw_fatal_fault, .numeric_fault, .ext_fault, .ext_fault_fatal, .step_ptr, .in_isr,
  .in_sub, .running, .stopped, .outputs_off, .error_flags, .summary_error_flag, .warning);

//--- testbench/test_program_scheduler_error_handler.sv
`include "sched_regs.svh"
module test_program_scheduler_error_handler;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0, rst = 1'h1, run_req = 1'h0, step_done = 1'h0, call_req = 1'h0;
  logic sub_return = 1'h0, isr_done = 1'h0, err_clear = 1'h0, ext_fault_fatal = 1'h0;
  logic [`STEP_W-1:0] last_step = 16'h0003, call_target = 16'h0040, step_ptr;
  logic [`NUM_EVENT-1:0] event_enable = 6'h00, input_event_interrupt;
  logic [2*`NUM_EVENT-1:0] event_edge_sel = 12'hfff;
  logic [5:0] flt = 6'h00; // fault inputs by flag bit
  logic [`NUM_PERIODIC-1:0] periodic_enable = 8'h00;
  logic [`NUM_PERIODIC*`PERIOD_W-1:0] periodic_interrupt_setting = 128'h0;
  logic watchdog_service_instruction = 1'h0;
  logic counter_compare_interrupt, in_isr, in_sub, running, stopped, outputs_off, warning;
  logic summary_error_flag;
  logic [`SRC_W-1:0] interrupt_point_index;
  logic [`ERR_W-1:0] error_flags;
  int n_mismatch = 0, compares = 0;
  always #2.5 ref_clk = ~ref_clk;
  program_scheduler_error_handler program_scheduler_error_handler_i (.ref_clk, .rst,
    .run_req, .last_step, .step_done, .call_req, .call_target, .sub_return, .isr_done,
    .periodic_enable, .periodic_interrupt_setting, .input_event_interrupt,
    .event_enable, .event_edge_sel, .counter_compare_interrupt, .wdog_units(10'h258),
    .watchdog_service_instruction, .config_mismatch(flt[0]), .io_fault(flt[2]),
    .numeric_fault(flt[3]), .hw_fatal_fault(flt[4]), .ext_fault(flt[5]), .ext_fault_fatal,
    .err_clear, .step_ptr, .in_isr, .interrupt_point_index, .in_sub, .running, .stopped,
    .outputs_off, .error_flags, .summary_error_flag, .warning);
  event_partner event_partner_i (.ref_clk, .input_event_interrupt, .counter_compare_interrupt);
  //////////////////////////////////////////////////////////////////////////////
  // shared helpers; inputs change on the falling edge only
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // wait bounded for a routine, then finish it
  task automatic serve(input logic [3:0] idx, input logic [15:0] sp);
    for (int n = 0; n < 10 && in_isr !== 1'h1; n++) tick();
    check(in_isr, 1'h1, "entered");
    check(interrupt_point_index, idx, "source");
    isr_done = 1'h1;
    tick();
    isr_done = 1'h0;
    check(in_isr, 1'h0, "left");
    check(step_ptr, sp, "resume");
  endtask
  task automatic no_isr();
    tick(6);
    check(in_isr, 1'h0, "no routine");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // start, then walk the scan through its wrap
  task automatic scan_scn();
    run_req = 1'h1;
    tick();
    run_req = 1'h0;
    check(step_ptr, 16'h0000, "first step");
    step_done = 1'h1;
    for (int i = 1; i <= 5; i++) begin
      tick();
      check(step_ptr, 16'(i % 4), "step");
    end
    step_done = 1'h0;
  endtask
  // periodic sources armed with the shortest period: a full 1 ms tick lies beyond
  // this run, so only the absence of an early request and a harmless service are seen
  task automatic periodic_scn();
    periodic_interrupt_setting = {8{16'h0001}};
    periodic_enable = 8'hff;
    watchdog_service_instruction = 1'h1;
    tick();
    watchdog_service_instruction = 1'h0;
    check(running, 1'h1, "serviced");
    tick(8);
    check(in_isr, 1'h0, "early period");
    periodic_enable = 8'h00;
  endtask
  // each event source in turn, modes rise, fall, both
  task automatic events_scn();
    logic [15:0] sp;
    sp = step_ptr;
    for (int i = 0; i < 6; i++) begin
      event_enable = 6'h01 << i;
      event_edge_sel = 12'hfff;
      event_edge_sel[2*i +: 2] = 2'(i % 3);
      event_partner_i.set_events(6'h01 << i);
      if (i % 3 == 1) no_isr(); else serve(4'(8 + i), sp);
      event_partner_i.set_events(6'h00);
      if (i % 3 == 0) no_isr(); else serve(4'(8 + i), sp);
    end
  endtask
  // requests together: served lowest first, never nested
  task automatic prio_scn();
    event_enable = 6'h3f;
    event_edge_sel = 12'h000;
    // the event path has one more register stage than the match, so the match
    // starts a cycle later and all three requests turn pending on one edge
    fork
      event_partner_i.set_events(6'h14);
      begin
        tick();
        event_partner_i.pulse_match(3);
      end
    join
    serve(4'ha, step_ptr);
    serve(4'hc, step_ptr);
    serve(4'he, step_ptr);
    event_partner_i.set_events(6'h00);
    no_isr();
  endtask
  // call, a refused second call, return
  task automatic call_scn();
    logic [15:0] sp;
    sp = step_ptr;
    call_req = 1'h1;
    tick();
    check(step_ptr, 16'h0040, "target");
    call_target = 16'h0080;
    tick();
    call_req = 1'h0;
    check(step_ptr, 16'h0040, "nested");
    sub_return = 1'h1;
    tick();
    sub_return = 1'h0;
    check({in_sub, step_ptr[14:0]}, {1'h0, 15'(sp + 16'h0001)}, "return");
  endtask
  // every fault input but the watchdog; ordinary ones leave the scan running
  task automatic faults_scn();
    int b;
    logic is_stop;
    for (int k = 0; k < 6; k++) begin
      b = (k == 1) ? 5 : k;
      is_stop = (k != 3 && k != 5);
      ext_fault_fatal = (k == 1);
      flt[b] = 1'h1;
      tick();
      flt[b] = 1'h0;
      check(error_flags, 6'h01 << b, "flag");
      check(summary_error_flag, 1'h1, "summary");
      check({stopped, outputs_off, warning}, {is_stop, is_stop, !is_stop}, "class");
      err_clear = 1'h1;
      run_req = is_stop;
      tick();
      {err_clear, run_req} = 2'h0;
      check({running, error_flags}, 7'h40, "restart");
    end
  endtask
  initial begin
    tick(20);
    rst = 1'h0;
    scan_scn();
    periodic_scn();
    events_scn();
    prio_scn();
    call_scn();
    faults_scn();
    give_verdict();
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict();
  end
endmodule // test_program_scheduler_error_handler
